// ### shared/adcl_pkg.sv
// constants for the lvds output and sync block
package adcl_pkg;
  // register offsets
  localparam logic [11:0] OFS_SYNC_CTRL0 = 12'h120;
  localparam logic [11:0] OFS_SYNC_CTRL1 = 12'h121;
  localparam logic [11:0] OFS_SYNC_STAT = 12'h128;
  localparam logic [11:0] OFS_OUT_MODE = 12'h568;
  localparam logic [11:0] OFS_DCO_PHASE = 12'h569;
  localparam logic [11:0] OFS_DRIVE = 12'h56a;
  // output_mode_select fields
  localparam int MODE_LSB = 0;
  localparam int FMT_LSB = 4;
  localparam logic [3:0] MODE_PAR_IL = 4'h1;
  localparam logic [3:0] MODE_PAR_MUX = 4'h3;
  localparam logic [3:0] MODE_BYTE2 = 4'h5;
  localparam logic [3:0] MODE_BYTE4 = 4'h6;
  localparam logic [3:0] MODE_BYTE8 = 4'h7;
  localparam logic [1:0] FMT_OFFSET = 2'h0;
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam logic [1:0] FMT_GRAY = 2'h2;
  // sync control fields
  localparam int SYC_EN_BIT = 0;
  localparam int SYC_FALL_BIT = 1;
  localparam int SYC_NEGCLK_BIT = 2;
  localparam int SYC_SKIP_LSB = 0;
  localparam int SYC_CAPT_BIT = 7;
  localparam logic [4:0] SYC_SKIP_MAX = 5'h10;
  // reset values
  localparam logic [7:0] RST_OUT_MODE = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // pipeline latencies in converter clocks
  localparam int SAMPLE_LAT = 33;
  localparam int OVR_LAT = 28;
  // window monitor figures
  localparam logic [3:0] WIN_GOOD = 4'h8;
  localparam logic [3:0] WIN_HOLD_BASE = 4'hf;
endpackage : adcl_pkg

// ### design/adcl_delay.sv
// fixed-depth pipeline delay line
`timescale 1ns/100ps
`default_nettype none
module adcl_delay #(
  parameter int W = 32,
  parameter int D = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] sr_q [D];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < D; i++) sr_q[i] <= '0;
    end
    else
    begin
      sr_q[0] <= din;
      for (int i = 1; i < D; i++) sr_q[i] <= sr_q[i-1];
    end
  end

  assign dout = sr_q[D-1];
endmodule : adcl_delay
`default_nettype wire

// ### design/adcl_sync.sv
// sync capture, event skip and setup/hold window monitor
`timescale 1ns/100ps
`default_nettype none
module adcl_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sync pin
  input wire logic sync_in,
  // configuration
  input wire logic enable,
  input wire logic fall_trans,
  input wire logic neg_clk,
  input wire logic [4:0] skip,
  input wire logic rearm,
  // results
  output logic resync,
  output logic captured,
  output logic [3:0] setup,
  output logic [3:0] hold
);
  logic p1_q, p2_q, n1_q, n2_q, prev_q, armed_q, hmon_q;
  logic [3:0] stb_q, hcnt_q;
  logic [4:0] cnt_q;
  localparam logic [3:0] WIN_GOOD_C = adcl_pkg::WIN_GOOD;

  // falling-edge capture path; only the second stage reads it
  always_ff @(negedge clk or posedge rst)
  begin
    if (rst) n1_q <= 1'b0;
    else n1_q <= sync_in;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      p1_q <= 1'b0;
      p2_q <= 1'b0;
      n2_q <= 1'b0;
    end
    else
    begin
      p1_q <= sync_in;
      p2_q <= p1_q;
      n2_q <= n1_q;
    end
  end

  wire smp = neg_clk ? n2_q : p2_q;
  wire trans = smp != prev_q;
  wire evt = trans && (fall_trans ? !smp : smp);
  wire fire = evt && enable && armed_q && (cnt_q >= skip);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= 1'b0;
      stb_q <= 4'h0;
      cnt_q <= 5'h00;
      armed_q <= 1'b1;
      resync <= 1'b0;
      captured <= 1'b0;
      setup <= 4'h0;
      hold <= 4'h0;
      hmon_q <= 1'b0;
      hcnt_q <= 4'h0;
    end
    else
    begin
      prev_q <= smp;
      stb_q <= trans ? 4'h0 : (stb_q == 4'hf ? stb_q : stb_q + 4'h1);
      resync <= fire;
      if (rearm)
      begin
        armed_q <= 1'b1;
        cnt_q <= 5'h00;
        captured <= 1'b0;
      end
      else if (fire)
      begin
        armed_q <= 1'b0;
        captured <= 1'b1;
        setup <= (stb_q >= WIN_GOOD_C) ? WIN_GOOD_C : stb_q;
        hmon_q <= 1'b1;
        hcnt_q <= 4'h0;
      end
      else if (evt && enable && armed_q)
        cnt_q <= cnt_q + 5'h01;
      // hold side: how long the new level lasted after the edge
      if (hmon_q && !fire)
      begin
        hcnt_q <= hcnt_q + 4'h1;
        if (trans)
        begin
          hold <= adcl_pkg::WIN_HOLD_BASE - hcnt_q;
          hmon_q <= 1'b0;
        end
        else if (hcnt_q == WIN_GOOD_C - 4'h1)
        begin
          hold <= WIN_GOOD_C;
          hmon_q <= 1'b0;
        end
      end
    end
  end

endmodule : adcl_sync
`default_nettype wire

// ### design/adcl_out.sv
// lvds output formatter, pin mapping and sync top level
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - drive current register lowers lvds drive below standard level
// - samples coded offset binary, two's complement or gray
// - power-down puts every digital output into high impedance
// - samples leave 33 clocks after entry, launched on rising edge
// - data clock driven with lanes; its phase set by register
// - overrange shown 28 clocks after it occurs
// - mode register reassigns pin functions, parallel or byte
// - mode 0x1 interleaves both channels on fourteen lanes
// - mode 0x3 puts channel a on upper, b on lower seven lanes
// - modes 0x5, 0x6, 0x7 carry two, four, eight converters bytewise
// - status pin overrange or frame clock; d13 status; d12-d5 byte
// - captured sync event resynchronises divider, converters, monitor link
// - sync event is rising or falling transition, chosen by software
// - sync sampled on rising or falling converter clock edge
// - up to 16 leading sync events ignored; options in two registers
// - setup level before edge in bits 3:0, hold after in 7:4
// - secondary sync control bit 7 shows whether sync input was captured
// - hold 0 with setup 0-7 setup error; 0x8 in either is fine
// - hold 9-f with setup 0 hold error; both zero either error
module adcl_out (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // register port
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  output logic [7:0] REG_RDATA,
  // converter samples, two's complement, left justified
  input wire logic [15:0] SAMPLE_A,
  input wire logic [15:0] SAMPLE_B,
  input wire logic OVR_A,
  input wire logic OVR_B,
  // virtual converter words for byte mode
  input wire logic [127:0] VC_DATA,
  input wire logic [7:0] VC_OVR,
  // pins
  input wire logic PWDN,
  input wire logic SYNC_IN,
  // lvds lanes
  output logic DCO_OUT,
  output logic STATUS_OUT,
  output logic [13:0] DATA_OUT,
  output logic OUT_OE,
  output logic [7:0] DRIVE_LEVEL,
  // resynchronisation strobe
  output logic RESYNC
);
  // configuration registers
  logic [7:0] sctl0_q, sctl1_q, mode_q, phase_q, drive_q;
  logic [7:0] rdata_d;
  // pin synchronisers
  logic pd1_q, pd2_q;
  // output pipeline
  logic ph_q;
  logic [3:0] bcnt_q, bcnt_d;
  logic [127:0] frame_q, frame_d;
  logic [7:0] vovr_q;
  logic [13:0] data_q, data_d;
  logic stat_q, stat_d;
  logic oe_q;
  // sync results
  logic sy_capt;
  logic [3:0] sy_setup, sy_hold;
  // delayed samples
  logic [31:0] dly_ab;
  logic [1:0] dly_ovr;

  // number coding of one 16-bit word
  function automatic logic [15:0] fmt_word(input logic [15:0] x, input logic [1:0] code);
    logic [15:0] ob;
    ob = {~x[15], x[14:0]};
    if (code == adcl_pkg::FMT_TWOS) fmt_word = x;
    else if (code == adcl_pkg::FMT_GRAY) fmt_word = ob ^ {1'b0, ob[15:1]};
    else fmt_word = ob;
  endfunction : fmt_word

  // last byte index of a frame for a byte mode
  function automatic logic [3:0] frame_last(input logic [3:0] m);
    if (m == adcl_pkg::MODE_BYTE8) frame_last = 4'hf;
    else if (m == adcl_pkg::MODE_BYTE4) frame_last = 4'h7;
    else frame_last = 4'h3;
  endfunction : frame_last

  // register decode
  wire hit_sctl0 = REG_ADDR == adcl_pkg::OFS_SYNC_CTRL0;
  wire hit_sctl1 = REG_ADDR == adcl_pkg::OFS_SYNC_CTRL1;
  wire hit_sstat = REG_ADDR == adcl_pkg::OFS_SYNC_STAT;
  wire hit_mode = REG_ADDR == adcl_pkg::OFS_OUT_MODE;
  wire hit_phase = REG_ADDR == adcl_pkg::OFS_DCO_PHASE;
  wire hit_drive = REG_ADDR == adcl_pkg::OFS_DRIVE;
  wire wr_sctl0 = REG_WE && hit_sctl0;

  // captured flag shares the secondary control byte; window fields fill sync_window_status
  wire [7:0] sctl1_rd = {sy_capt, sctl1_q[6:0]};
  wire [7:0] sstat_rd = {sy_hold, sy_setup};

  assign rdata_d = hit_sctl0 ? sctl0_q :
                   hit_sctl1 ? sctl1_rd :
                   hit_sstat ? sstat_rd :
                   hit_mode ? mode_q :
                   hit_phase ? phase_q :
                   hit_drive ? drive_q :
                   adcl_pkg::RST_ZERO;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      sctl0_q <= adcl_pkg::RST_ZERO;
      sctl1_q <= adcl_pkg::RST_ZERO;
      mode_q <= adcl_pkg::RST_OUT_MODE;
      phase_q <= adcl_pkg::RST_ZERO;
      drive_q <= adcl_pkg::RST_ZERO;
      REG_RDATA <= adcl_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_sctl0) sctl0_q <= REG_WDATA;
      if (REG_WE && hit_sctl1) sctl1_q <= {1'b0, REG_WDATA[6:0]};
      if (REG_WE && hit_mode) mode_q <= REG_WDATA;
      if (REG_WE && hit_phase) phase_q <= REG_WDATA;
      if (REG_WE && hit_drive) drive_q <= REG_WDATA;
      REG_RDATA <= rdata_d;
    end
  end

  // register fields
  wire [3:0] mode = mode_q[adcl_pkg::MODE_LSB +: 4];
  wire [1:0] fcode = mode_q[adcl_pkg::FMT_LSB +: 2];
  wire [4:0] skip_raw = sctl1_q[adcl_pkg::SYC_SKIP_LSB +: 5];
  // more than sixteen would be meaningless, so clamp
  wire [4:0] skip = (skip_raw > adcl_pkg::SYC_SKIP_MAX) ? adcl_pkg::SYC_SKIP_MAX : skip_raw;

  // power-down pin is asynchronous to the sample clock
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pd1_q <= 1'b0;
      pd2_q <= 1'b0;
    end
    else
    begin
      pd1_q <= PWDN;
      pd2_q <= pd1_q;
    end
  end

  // sync capture and window monitor
  adcl_sync u_sync (
    .clk(MCLK),
    .rst(RST),
    .sync_in(SYNC_IN),
    .enable(sctl0_q[adcl_pkg::SYC_EN_BIT]),
    .fall_trans(sctl0_q[adcl_pkg::SYC_FALL_BIT]),
    .neg_clk(sctl0_q[adcl_pkg::SYC_NEGCLK_BIT]),
    .skip(skip),
    .rearm(wr_sctl0),
    .resync(RESYNC),
    .captured(sy_capt),
    .setup(sy_setup),
    .hold(sy_hold)
  );

  // sample pipeline; the output flop makes the launch edge
  adcl_delay #(
    .W(32),
    .D(adcl_pkg::SAMPLE_LAT)
  ) u_smp_dly (
    .clk(MCLK),
    .rst(RST),
    .din({SAMPLE_A, SAMPLE_B}),
    .dout(dly_ab)
  );

  // overrange runs a shorter pipe than the samples
  adcl_delay #(
    .W(2),
    .D(adcl_pkg::OVR_LAT)
  ) u_ovr_dly (
    .clk(MCLK),
    .rst(RST),
    .din({OVR_A, OVR_B}),
    .dout(dly_ovr)
  );

  // coded channel words
  wire [15:0] word_a = fmt_word(dly_ab[31:16], fcode);
  wire [15:0] word_b = fmt_word(dly_ab[15:0], fcode);
  wire ovr_a = dly_ovr[1];
  wire ovr_b = dly_ovr[0];

  // next output half: high phase carries channel b
  wire sel_b = !ph_q;

  // parallel lane contents
  wire [13:0] lanes_il = sel_b ? word_b[15:2] : word_a[15:2];
  wire [13:0] lanes_mux = sel_b ? {word_a[8:2], word_b[8:2]} :
                          {word_a[15:9], word_b[15:9]};
  wire stat_par = sel_b ? ovr_b : ovr_a;

  // byte mode framing
  wire byte_mode = (mode == adcl_pkg::MODE_BYTE2) ||
                   (mode == adcl_pkg::MODE_BYTE4) ||
                   (mode == adcl_pkg::MODE_BYTE8);
  wire [3:0] blast = frame_last(mode);
  wire frame_end = bcnt_q == blast;
  wire [3:0] nconv = 4'((5'(blast) + 5'h01) >> 1);
  wire [6:0] widx = {bcnt_q[3:1], 4'h0};
  wire [15:0] wcur = frame_q[widx +: 16];
  // upper byte first within each converter word
  wire [7:0] bcur = bcnt_q[0] ? wcur[7:0] : wcur[15:8];
  wire vstat = vovr_q[bcnt_q[3:1]];
  wire frame_clock_out = bcnt_q < nconv;

  assign bcnt_d = (!byte_mode || frame_end) ? 4'h0 : bcnt_q + 4'h1;

  // whole frame is latched at once so words never tear mid-frame
  always_comb
  begin
    frame_d = frame_q;
    if (!byte_mode || frame_end)
    begin
      for (int i = 0; i < 8; i++)
        frame_d[i*16 +: 16] = fmt_word(VC_DATA[i*16 +: 16], fcode);
    end
  end

  // pin function selection
  always_comb
  begin
    data_d = 14'h0000;
    stat_d = 1'b0;
    case (mode)
      adcl_pkg::MODE_PAR_IL:
      begin
        data_d = lanes_il;
        stat_d = stat_par;
      end
      adcl_pkg::MODE_PAR_MUX:
      begin
        data_d = lanes_mux;
        stat_d = stat_par;
      end
      adcl_pkg::MODE_BYTE2, adcl_pkg::MODE_BYTE4, adcl_pkg::MODE_BYTE8:
      begin
        data_d = {vstat, bcur, 5'h00};
        stat_d = frame_clock_out;
      end
      default:
      begin
        data_d = 14'h0000;
        stat_d = 1'b0;
      end
    endcase
  end

  // output launch flops, all on the rising edge
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ph_q <= 1'b0;
      bcnt_q <= 4'h0;
      frame_q <= '0;
      vovr_q <= 8'h00;
      data_q <= 14'h0000;
      stat_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      ph_q <= sel_b;
      bcnt_q <= bcnt_d;
      frame_q <= frame_d;
      if (!byte_mode || frame_end) vovr_q <= VC_OVR;
      data_q <= data_d;
      stat_q <= stat_d;
      oe_q <= !pd2_q;
    end
  end

  // data clock edges line up with lane changes; phase bit flips it
  assign DCO_OUT = ph_q ^ phase_q[0];
  assign DATA_OUT = data_q;
  assign STATUS_OUT = stat_q;
  // pads float while powered down; enables cover every lane
  assign OUT_OE = oe_q;
  assign DRIVE_LEVEL = drive_q;
endmodule : adcl_out
`default_nettype wire

// ### dv/adcl_rx.sv
// capture register on the receiving side of the lanes
`timescale 1ns/100ps
`default_nettype none
module adcl_rx (
  // lanes
  input wire logic MCLK,
  input wire logic DCO_OUT,
  input wire logic STATUS_OUT,
  input wire logic [13:0] DATA_OUT,
  input wire logic OUT_OE,
  // words caught in the low and high data clock phase
  output logic [14:0] lo_word,
  output logic [14:0] hi_word
);
  // mid-cycle capture keeps clear of the lane flops switching
  always @(negedge MCLK)
  begin
    if (OUT_OE && !DCO_OUT) lo_word <= {STATUS_OUT, DATA_OUT};
    if (OUT_OE && DCO_OUT) hi_word <= {STATUS_OUT, DATA_OUT};
  end
endmodule : adcl_rx
`default_nettype wire

// ### dv/adcl_out_chk.sv
// port assertions for the lvds output and sync block
`timescale 1ns/100ps
`default_nettype none
module adcl_out_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // register port
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic [7:0] REG_RDATA,
  // samples and pins
  input wire logic [15:0] SAMPLE_A,
  input wire logic [15:0] SAMPLE_B,
  input wire logic OVR_A,
  input wire logic PWDN,
  // lanes
  input wire logic DCO_OUT,
  input wire logic STATUS_OUT,
  input wire logic [13:0] DATA_OUT,
  input wire logic OUT_OE,
  input wire logic [7:0] DRIVE_LEVEL,
  input wire logic RESYNC
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [7:0] mode_q;
  logic ph_q;
  logic en_q;
  logic [5:0] calm_q;
  wire md_wr = REG_WE && (REG_ADDR == adcl_pkg::OFS_OUT_MODE);
  wire ph_wr = REG_WE && (REG_ADDR == adcl_pkg::OFS_DCO_PHASE);
  wire en_wr = REG_WE && (REG_ADDR == adcl_pkg::OFS_SYNC_CTRL0);
  wire mapped = REG_ADDR inside {adcl_pkg::OFS_SYNC_CTRL0, adcl_pkg::OFS_SYNC_CTRL1,
    adcl_pkg::OFS_SYNC_STAT, adcl_pkg::OFS_OUT_MODE, adcl_pkg::OFS_DCO_PHASE,
    adcl_pkg::OFS_DRIVE};
  // lane checks wait for the pipeline to refill after a mode or phase write
  wire calm = (calm_q == 6'h3f) && !ph_q;
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST) {mode_q, ph_q, en_q, calm_q} <= {adcl_pkg::RST_OUT_MODE, 8'h00};
    else
    begin
      if (md_wr) mode_q <= REG_WDATA;
      if (ph_wr) ph_q <= REG_WDATA[0];
      if (en_wr) en_q <= REG_WDATA[adcl_pkg::SYC_EN_BIT];
      calm_q <= (md_wr || ph_wr) ? 6'h00 : calm_q + 6'(calm_q != 6'h3f);
    end
  end
  a_drive_copy: assert property ((REG_WE && REG_ADDR == adcl_pkg::OFS_DRIVE) |-> ##2
    DRIVE_LEVEL == $past(REG_WDATA, 2)) else $error("drive level not copied");
  a_unmapped_zero: assert property (!mapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_pwdn_float: assert property (PWDN [*5] |-> !OUT_OE) else $error("lanes driven in pwdn");
  a_oe_back: assert property (!PWDN [*5] |-> OUT_OE) else $error("lanes not driven");
  a_dco_runs: assert property (calm |-> DCO_OUT != $past(DCO_OUT))
    else $error("data clock stalled");
  a_il_latency: assert property ((calm && mode_q == 8'h11 && !DCO_OUT) |->
    DATA_OUT == $past(SAMPLE_A[15:2], 34)) else $error("interleaved sample wrong");
  a_ovr_latency: assert property ((calm && mode_q == 8'h11 && !DCO_OUT) |->
    STATUS_OUT == $past(OVR_A, 29)) else $error("overrange lane wrong");
  a_mux_lanes: assert property ((calm && mode_q == 8'h13 && !DCO_OUT) |->
    DATA_OUT == {$past(SAMPLE_A[15:9], 34), $past(SAMPLE_B[15:9], 34)})
    else $error("multiplexed lanes wrong");
  a_byte_unused: assert property ((calm && mode_q[3:0] inside {4'h5, 4'h6, 4'h7}) |->
    DATA_OUT[4:0] == 5'h00) else $error("unused byte lanes busy");
  a_resync_pulse: assert property (RESYNC |=> !RESYNC) else $error("resync too long");
  a_resync_enabled: assert property (RESYNC |-> en_q) else $error("resync while off");
  c_resync: cover property (RESYNC);
  c_byte8: cover property (calm && mode_q[3:0] == adcl_pkg::MODE_BYTE8 && STATUS_OUT);
  c_float: cover property (PWDN && !OUT_OE);
endmodule : adcl_out_chk
bind adcl_out adcl_out_chk u_chk (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RDATA(REG_RDATA), .SAMPLE_A(SAMPLE_A),
  .SAMPLE_B(SAMPLE_B), .OVR_A(OVR_A), .PWDN(PWDN), .DCO_OUT(DCO_OUT),
  .STATUS_OUT(STATUS_OUT), .DATA_OUT(DATA_OUT), .OUT_OE(OUT_OE),
  .DRIVE_LEVEL(DRIVE_LEVEL), .RESYNC(RESYNC));
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the lvds output and sync block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk, rst, we, ovr_a, ovr_b, pwdn, sync_in;
  logic [11:0] addr;
  logic [7:0] wdata, d, vc_ovr;
  logic [15:0] sa, sb, r;
  logic [127:0] vc_data;
  wire logic data_clock_out, stat, oe, resync;
  wire logic [13:0] dout;
  wire logic [7:0] drv, rdata;
  wire logic [14:0] rx_lo, rx_hi;
  int num_errors = 0;
  int checked = 0;
  adcl_out dut (.MCLK(mclk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we),
    .REG_RDATA(rdata), .SAMPLE_A(sa), .SAMPLE_B(sb), .OVR_A(ovr_a), .OVR_B(ovr_b),
    .VC_DATA(vc_data), .VC_OVR(vc_ovr), .PWDN(pwdn), .SYNC_IN(sync_in), .DCO_OUT(data_clock_out),
    .STATUS_OUT(stat), .DATA_OUT(dout), .OUT_OE(oe), .DRIVE_LEVEL(drv), .RESYNC(resync));
  adcl_rx rx (.MCLK(mclk), .DCO_OUT(data_clock_out), .STATUS_OUT(stat), .DATA_OUT(dout),
    .OUT_OE(oe), .lo_word(rx_lo), .hi_word(rx_hi));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge mclk) {addr, wdata, we} <= {a, v, 1'b1};
    @(posedge mclk) we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge mclk) addr <= a;
    tick(1);
    d = rdata;
  endtask : rd
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // drive the sync pin, then count resync strobes over n cycles
  task automatic sy(input logic v, input int n);
    @(posedge mclk) sync_in <= v;
    r = 16'h0000;
    repeat (n)
    begin
      tick(1);
      r = r + {15'h0000, resync === 1'b1};
    end
  endtask : sy
  // lane coding of a two's complement word; gray is taken over offset binary
  function automatic logic [13:0] enc(input logic [1:0] f, input logic [15:0] s);
    logic [13:0] o;
    o = s[15:2] ^ {f != 2'h1, 13'h0000};
    return (f == 2'h2) ? (o ^ (o >> 1)) : o;
  endfunction : enc
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  initial
  begin
    #60000;
    num_errors++;
    conclude();
  end
  initial
  begin
    {rst, we, ovr_a, ovr_b, pwdn, sync_in} = 6'b100100;
    {addr, wdata, sa, sb} = {20'h00000, 16'h1234, 16'hfffc};
    {vc_data, vc_ovr} = {{8{16'ha55a}}, 8'hff};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(adcl_pkg::OFS_OUT_MODE);
    cmp({8'h00, d}, {8'h00, adcl_pkg::RST_OUT_MODE});
    wr(adcl_pkg::OFS_DRIVE, 8'h5a);
    wr(adcl_pkg::OFS_SYNC_STAT, 8'hff);
    wr(12'h200, 8'hff);
    rd(adcl_pkg::OFS_DRIVE);
    cmp({d, drv}, 16'h5a5a);
    rd(adcl_pkg::OFS_SYNC_STAT);
    cmp({8'h00, d}, 16'h0000);
    rd(12'h200);
    cmp({8'h00, d}, 16'h0000);
    for (int f = 0; f < 3; f++)
    begin
      wr(adcl_pkg::OFS_OUT_MODE, {2'b00, 2'(f), adcl_pkg::MODE_PAR_IL});
      tick(45);
      cmp({1'b0, rx_lo}, {1'b0, ovr_a, enc(2'(f), sa)});
      cmp({1'b0, rx_hi}, {1'b0, ovr_b, enc(2'(f), sb)});
    end
    wr(adcl_pkg::OFS_OUT_MODE, 8'h11);
    wr(adcl_pkg::OFS_DCO_PHASE, 8'h01);
    tick(45);
    cmp({1'b0, rx_lo}, {1'b0, ovr_b, sb[15:2]});
    wr(adcl_pkg::OFS_DCO_PHASE, 8'h00);
    wr(adcl_pkg::OFS_OUT_MODE, 8'h13);
    tick(45);
    while (data_clock_out !== 1'b0) tick(1);
    cmp({2'b00, dout}, {2'b00, sa[15:9], sb[15:9]});
    wr(adcl_pkg::OFS_OUT_MODE, 8'h10);
    tick(45);
    cmp({1'b0, stat, dout}, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      wr(adcl_pkg::OFS_OUT_MODE, 8'h15 + 8'(i));
      tick(45);
      while (stat !== 1'b0) tick(1);
      while (stat !== 1'b1) tick(1);
      cmp({2'b00, dout}, {3'b001, 8'ha5, 5'h00});
      tick(1);
      cmp({2'b00, dout}, {3'b001, 8'h5a, 5'h00});
      r = 16'h0001;
      while (stat === 1'b1 && r < 16'h0020)
      begin
        tick(1);
        r = r + 16'h0001;
      end
      cmp(r, 16'h0002 << i);
    end
    @(posedge mclk) pwdn <= 1'b1;
    tick(5);
    cmp({15'h0000, oe}, 16'h0000);
    @(posedge mclk) pwdn <= 1'b0;
    tick(5);
    cmp({15'h0000, oe}, 16'h0001);
    wr(adcl_pkg::OFS_SYNC_CTRL0, 8'h01);
    sy(1'b1, 12);
    cmp(r, 16'h0001);
    rd(adcl_pkg::OFS_SYNC_CTRL1);
    cmp({15'h0000, d[adcl_pkg::SYC_CAPT_BIT]}, 16'h0001);
    rd(adcl_pkg::OFS_SYNC_STAT);
    cmp({8'h00, d}, 16'h0088);
    sy(1'b0, 12);
    sy(1'b1, 12);
    cmp(r, 16'h0000);
    wr(adcl_pkg::OFS_SYNC_CTRL1, 8'h02);
    wr(adcl_pkg::OFS_SYNC_CTRL0, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      sy(1'b0, 12);
      cmp(r, {15'h0000, i == 2});
      sy(1'b1, 12);
      cmp(r, 16'h0000);
    end
    wr(adcl_pkg::OFS_SYNC_CTRL1, 8'h00);
    wr(adcl_pkg::OFS_SYNC_CTRL0, 8'h05);
    sy(1'b0, 12);
    sy(1'b1, 12);
    cmp(r, 16'h0001);
    wr(adcl_pkg::OFS_SYNC_CTRL0, 8'h01);
    sy(1'b0, 12);
    sy(1'b1, 2);
    sy(1'b0, 12);
    rd(adcl_pkg::OFS_SYNC_STAT);
    cmp({11'h000, d[7:4] >= 4'h9, d[3:0]}, 16'h0018);
    conclude();
  end
endmodule : testbench
`default_nettype wire
